/* File: verilog/pacer_pkg.sv */
// constants shared by the pacer and pre-trigger counter block
package pacer_pkg;
	localparam int CNT_W = 16;
	localparam int MODE_W = 3;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [2:0] MODE_EVENT = 3'h0;
	localparam logic [2:0] MODE_ONESHOT = 3'h1;
	localparam logic [2:0] MODE_RATE = 3'h2;
	localparam logic [2:0] MODE_SQUARE = 3'h3;
	localparam logic [2:0] MODE_SWSTROBE = 3'h4;
	localparam logic [2:0] MODE_HWSTROBE = 3'h5;
	localparam int MCLK_HZ = 125_000_000;
	localparam int BASE_HZ = 2_000_000;
	// base tick spacing in MCLK cycles, rounded down
	localparam int BASE_DIV = MCLK_HZ / BASE_HZ;
	localparam logic [1:0] PAIR_CNT = 2'h3;
endpackage

/* File: verilog/down_counter.sv */
// one programmable down counter with six operating modes
`timescale 1ns/10ps
module down_counter
	import pacer_pkg::*;
#(
	parameter int W = CNT_W
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [W-1:0] load_value,
	input wire logic [2:0] mode,
	input wire logic tick,
	input wire logic gate,
	input wire logic gate_rise,
	output logic [W-1:0] count,
	output logic out,
	output logic pulse
);
	logic armed;
	logic [W-1:0] reload;
	wire periodic = (mode == MODE_RATE) || (mode == MODE_SQUARE);
	wire retrig = (mode == MODE_ONESHOT) || (mode == MODE_HWSTROBE);
	wire [W-1:0] dec = count - {{(W-1){1'b0}}, 1'b1};
	wire at_one = (count == {{(W-1){1'b0}}, 1'b1});
	wire at_zero = (count == '0);
	wire gate_ok = retrig ? 1'b1 : gate;
	wire step = tick && gate_ok && armed;
	wire [W-1:0] half = reload >> 1;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			reload <= '0;
			armed <= 1'b0;
			out <= 1'b0;
			pulse <= 1'b0;
		end else begin
			pulse <= 1'b0;
			if (load) begin
				count <= load_value;
				reload <= load_value;
				armed <= (mode != MODE_ONESHOT) && (mode != MODE_HWSTROBE);
				out <= (mode == MODE_RATE) || (mode == MODE_SQUARE) || (mode == MODE_SWSTROBE);
			end else if (retrig && gate_rise) begin
				count <= reload;
				armed <= 1'b1;
				out <= (mode == MODE_HWSTROBE);
			end else if (step) begin
				// a divisor of zero acts as the full 65536 count
				if (periodic && at_one) begin
					count <= reload;
					pulse <= 1'b1;
					out <= (mode == MODE_SQUARE) ? ~out : 1'b1;
				end else begin
					count <= dec;
					if (mode == MODE_RATE && count == 16'h0002) begin
						out <= 1'b0;
					end else if (mode == MODE_SQUARE && count == half) begin
						out <= ~out;
					end else if ((mode == MODE_EVENT || mode == MODE_ONESHOT) && at_one) begin
						out <= 1'b1;
						pulse <= 1'b1;
						armed <= 1'b0;
					end else if ((mode == MODE_SWSTROBE || mode == MODE_HWSTROBE) && at_one) begin
						pulse <= 1'b1;
						armed <= 1'b0;
					end
				end
			end else if (!step && !at_zero && (mode == MODE_SWSTROBE || mode == MODE_HWSTROBE)) begin
				out <= 1'b1;
			end
		end
	end
endmodule

/* File: verilog/pacer_pretrigger.sv */
// pacer and pre-trigger counter block: three counters, chained pacer, stop counter
// Contract
// - three counters, each runs in any of six modes; counters 1 and 2 have gate_rise tied low, so they never arm in modes 1 and 5
// - counter 1 output clocks counter 2; chained output is the pacer trigger
// - pacer rate set only by the two loaded divisors
// - pacer runs from a 2 MHz base; least total division four, 500 kHz; the counters also take divisor 1, so the code allows total division one
// - each divisor up to 65536, loaded as zero; slowest rate is base over 65536 squared
// - counter 0 only counts conversions for the pre-trigger stop
// - counter 0 counts once per selected conversion trigger
// - counter 0 gate opens on a falling stop trigger input
// - counter 0 gate closes when it reaches zero
// - reaching zero disables the conversion trigger automatically
// - counter 0 value is readable so software can poll for the stop
`timescale 1ns/10ps
module pacer_pretrigger
	import pacer_pkg::*;
#(
	parameter int W = CNT_W
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [1:0] LOAD_SEL,
	input wire logic LOAD,
	input wire logic [W-1:0] LOAD_VALUE,
	input wire logic [2:0] LOAD_MODE,
	input wire logic PRETRIG_EN,
	input wire logic EXT_TRIG_SEL,
	input wire logic EXT_TRIG,
	input wire logic SOFT_TRIG,
	input wire logic STOP_TRIGGER_INPUT,
	output logic CONV_TRIG,
	output logic PACER_OUT,
	output logic [W-1:0] COUNT0,
	output logic [W-1:0] COUNT1,
	output logic [W-1:0] COUNT2,
	output logic GATE0,
	output logic STOPPED
);
	typedef enum logic [2:0] {
		ARMED = 3'b001,
		COUNTING = 3'b010,
		HALTED = 3'b100
	} pre_state_e;

	pre_state_e state;
	pre_state_e next_state;
	logic [6:0] base_cnt;
	logic base_tick;
	logic [2:0] mode [3];
	logic [2:0] stop_sync;
	logic stop_level;
	logic [2:0] ext_sync;
	logic ext_level;
	logic ext_prev;
	logic [W-1:0] cnt [3];
	logic cnt_out [3];
	logic cnt_pulse [3];
	logic conv_enable;

	function automatic logic sel_is(input logic [1:0] s, input int i);
		sel_is = (s == i[1:0]);
	endfunction

	// pins pass three flops; a level change counts once the last two agree
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			stop_sync <= 3'h7;
			stop_level <= 1'b1;
			ext_sync <= 3'h0;
			ext_level <= 1'b0;
			ext_prev <= 1'b0;
		end else begin
			stop_sync <= {stop_sync[1:0], STOP_TRIGGER_INPUT};
			ext_sync <= {ext_sync[1:0], EXT_TRIG};
			if (stop_sync[2] == stop_sync[1]) begin
				stop_level <= stop_sync[2];
			end
			if (ext_sync[2] == ext_sync[1]) begin
				ext_level <= ext_sync[2];
			end
			ext_prev <= ext_level;
		end
	end

	wire stop_fall = stop_sync[2] == stop_sync[1] && !stop_sync[2] && stop_level;
	wire ext_rise = ext_level && !ext_prev;

	// base tick every BASE_DIV cycles of MCLK, about 2 MHz
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			base_cnt <= '0;
			base_tick <= 1'b0;
		end else begin
			base_tick <= (base_cnt == 7'(BASE_DIV - 1));
			base_cnt <= (base_cnt == 7'(BASE_DIV - 1)) ? '0 : base_cnt + 7'h01;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			mode[0] <= MODE_RESET;
			mode[1] <= MODE_RESET;
			mode[2] <= MODE_RESET;
		end else if (LOAD) begin
			for (int i = 0; i < 3; i++) begin
				if (sel_is(LOAD_SEL, i)) begin
					mode[i] <= LOAD_MODE;
				end
			end
		end
	end

	// raw conversion trigger from the selected source, before the stop gate
	wire raw_trig = EXT_TRIG_SEL ? ext_rise : (cnt_pulse[2] || SOFT_TRIG);
	wire conv_now = raw_trig && conv_enable;

	// mode registers update a cycle late; the selected counter takes LOAD_MODE directly
	wire [2:0] load_mode_eff [3];
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_cnt
			assign load_mode_eff[g] = sel_is(LOAD_SEL, g) ? LOAD_MODE : mode[g];
		end
	endgenerate

	wire gate0 = (state == COUNTING);
	wire load0 = LOAD && sel_is(LOAD_SEL, 0);
	wire load1 = LOAD && sel_is(LOAD_SEL, 1);
	wire load2 = LOAD && sel_is(LOAD_SEL, 2);

	down_counter #(.W(W)) u_cnt0 (
		.mclk(MCLK),
		.rst_n(RST_N),
		.load(load0),
		.load_value(LOAD_VALUE),
		.mode(load_mode_eff[0]),
		.tick(conv_now),
		.gate(gate0),
		.gate_rise(stop_fall && state == ARMED),
		.count(cnt[0]),
		.out(cnt_out[0]),
		.pulse(cnt_pulse[0])
	);

	down_counter #(.W(W)) u_cnt1 (
		.mclk(MCLK),
		.rst_n(RST_N),
		.load(load1),
		.load_value(LOAD_VALUE),
		.mode(load_mode_eff[1]),
		.tick(base_tick),
		.gate(1'b1),
		.gate_rise(1'b0),
		.count(cnt[1]),
		.out(cnt_out[1]),
		.pulse(cnt_pulse[1])
	);

	// counter 2 steps on each period of counter 1, so the divisors multiply
	down_counter #(.W(W)) u_cnt2 (
		.mclk(MCLK),
		.rst_n(RST_N),
		.load(load2),
		.load_value(LOAD_VALUE),
		.mode(load_mode_eff[2]),
		.tick(cnt_pulse[1]),
		.gate(1'b1),
		.gate_rise(1'b0),
		.count(cnt[2]),
		.out(cnt_out[2]),
		.pulse(cnt_pulse[2])
	);

	// stop sequencer; counter 0 loaded with zero stops only after 65536 triggers, software keeps N >= 1
	always_comb begin
		next_state = state;
		case (state)
			ARMED: begin
				if (stop_fall) begin
					next_state = COUNTING;
				end
			end
			COUNTING: begin
				if (conv_now && cnt[0] == 16'h0001) begin
					next_state = HALTED;
				end
			end
			HALTED: begin
				next_state = HALTED;
			end
			default: begin
				next_state = ARMED;
			end
		endcase
		if (!PRETRIG_EN) begin
			next_state = ARMED;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= ARMED;
		end else begin
			state <= next_state;
		end
	end

	// mode 0 is assumed on counter 0; other modes also change how its count steps and reloads
	assign conv_enable = !(PRETRIG_EN && state == HALTED);

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			CONV_TRIG <= 1'b0;
			PACER_OUT <= 1'b0;
			COUNT0 <= CNT_RESET;
			COUNT1 <= CNT_RESET;
			COUNT2 <= CNT_RESET;
			GATE0 <= 1'b0;
			STOPPED <= 1'b0;
		end else begin
			CONV_TRIG <= conv_now;
			PACER_OUT <= cnt_out[2];
			COUNT0 <= cnt[0];
			COUNT1 <= cnt[1];
			COUNT2 <= cnt[2];
			GATE0 <= gate0;
			STOPPED <= (state == HALTED) && PRETRIG_EN;
		end
	end
endmodule

/* File: testbench/pacer_pretrigger_monitor.sv */
// assertions on the pacer and pre-trigger block ports
`timescale 1ns/10ps
module pacer_pretrigger_monitor #(
	parameter int W = 16
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic LOAD,
	input wire logic PRETRIG_EN,
	input wire logic STOP_TRIGGER_INPUT,
	input wire logic CONV_TRIG,
	input wire logic [W-1:0] COUNT0,
	input wire logic GATE0,
	input wire logic STOPPED
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	a_stop_quiet: assert property ($past(STOPPED) && $past(PRETRIG_EN) |-> !CONV_TRIG)
		else $error("trigger while stopped");
	a_stop_hold: assert property (STOPPED && PRETRIG_EN |=> STOPPED)
		else $error("stop dropped");
	a_rearm_clear: assert property (!PRETRIG_EN [*3] |-> !STOPPED)
		else $error("stop kept");
	a_gate_close: assert property ($rose(STOPPED) |-> ##[0:3] !GATE0)
		else $error("gate open at stop");
	a_stop_zero: assert property ($rose(STOPPED) |-> ##[0:2] COUNT0 == '0)
		else $error("stop with nonzero count");
	a_gate_open: assert property (
		$fell(STOP_TRIGGER_INPUT) && PRETRIG_EN && !STOPPED |-> ##[2:7] GATE0)
		else $error("gate not opened");
	a_count_step: assert property (
		$changed(COUNT0) && !$past(LOAD) && !$past(LOAD, 2) && !$past(LOAD, 3)
		|-> COUNT0 == $past(COUNT0) - 1'b1)
		else $error("count0 jumped");
	// the count may move a little before or after the registered trigger
	a_count_cause: assert property (
		$changed(COUNT0) && !$past(LOAD, 2) |-> ##[0:6] $past(CONV_TRIG, 3))
		else $error("count0 moved alone");
endmodule

bind pacer_pretrigger pacer_pretrigger_monitor #(.W(W)) i_pacer_pretrigger_monitor (
	.MCLK(MCLK), .RST_N(RST_N), .LOAD(LOAD), .PRETRIG_EN(PRETRIG_EN),
	.STOP_TRIGGER_INPUT(STOP_TRIGGER_INPUT), .CONV_TRIG(CONV_TRIG), .COUNT0(COUNT0),
	.GATE0(GATE0), .STOPPED(STOPPED));

/* File: testbench/host_model.sv */
// host and trigger pin model that programs and stimulates the counters
`timescale 1ns/10ps
module host_model (
	input wire logic clk,
	output logic [1:0] load_sel = 2'h3,
	output logic load = 1'b0,
	output logic [15:0] load_value = 16'h0000,
	output logic [2:0] load_mode = 3'h0,
	output logic ext_trig = 1'b0,
	output logic stop_in = 1'b1
);
	// value lines scrambled once released so stale data is never reused
	task automatic put(input logic [1:0] sel, input logic [15:0] val, input logic [2:0] md);
		@(posedge clk);
		#1;
		{load_sel, load_value, load_mode, load} = {sel, val, md, 1'b1};
		@(posedge clk);
		#1;
		{load_sel, load_value, load} = {2'h3, ~val, 1'b0};
	endtask
	task automatic arm(input logic [15:0] n);
		put(2'h0, n, 3'h0);
	endtask
	// held past the input synchroniser, then a quiet gap
	task automatic pulse();
		ext_trig = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		ext_trig = 1'b0;
		repeat (10) @(posedge clk);
		#1;
	endtask
endmodule

/* File: testbench/pacer_pretrigger_tb_top.sv */
// self-checking bench for the pacer and pre-trigger counter block
`timescale 1ns/10ps
module pacer_pretrigger_tb_top;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic pretrig_en = 1'b0;
	logic ext_sel = 1'b0;
	logic soft_trig = 1'b0;
	logic [1:0] load_sel;
	logic [15:0] load_value, count0, count1, count2;
	logic [2:0] load_mode;
	logic load, ext_trig, stop_in, conv_trig, pacer_out, gate0, stopped;
	int errors = 0;
	int tests_run = 0;
	int trigs = 0;
	always #4 mclk = ~mclk;
	always @(posedge mclk) if (conv_trig === 1'b1) trigs++;
	pacer_pretrigger i_pacer_pretrigger (.MCLK(mclk), .RST_N(rst_n), .LOAD_SEL(load_sel),
		.LOAD(load), .LOAD_VALUE(load_value), .LOAD_MODE(load_mode), .PRETRIG_EN(pretrig_en),
		.EXT_TRIG_SEL(ext_sel), .EXT_TRIG(ext_trig), .SOFT_TRIG(soft_trig),
		.STOP_TRIGGER_INPUT(stop_in), .CONV_TRIG(conv_trig), .PACER_OUT(pacer_out),
		.COUNT0(count0), .COUNT1(count1), .COUNT2(count2), .GATE0(gate0), .STOPPED(stopped));
	host_model i_host_model (.clk(mclk), .load_sel(load_sel), .load(load),
		.load_value(load_value), .load_mode(load_mode), .ext_trig(ext_trig), .stop_in(stop_in));
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// counter 0 only moves on triggers, so its loads read back exactly
	task automatic mode_test();
		for (int m = 0; m < 6; m++) begin
			i_host_model.put(2'h0, 16'h0040 + 16'(m), 3'(m));
			@(posedge mclk);
			#1;
			check("count0 load", 16'h0040 + 16'(m), count0);
		end
	endtask
	// third gap is measured; the first two may carry the old divisors
	task automatic pacer_test(input logic [15:0] d1, input logic [15:0] d2);
		int cyc;
		int lows;
		i_host_model.put(2'h1, d1, 3'h2);
		@(posedge mclk);
		#1;
		check("count1 load", d1, count1);
		i_host_model.put(2'h2, d2, 3'h2);
		@(posedge mclk);
		#1;
		check("count2 load", d2, count2);
		repeat (3) begin
			cyc = 0;
			lows = 0;
			do begin
				@(posedge mclk);
				#1 cyc++;
				lows += int'(pacer_out === 1'b0);
			end while (conv_trig !== 1'b1 && cyc < 3000);
		end
		check("pacer period", 16'(pacer_pkg::BASE_DIV * d1 * d2), 16'(cyc));
		// rate mode holds the output low for one counter 1 period
		check("pacer low", 16'(pacer_pkg::BASE_DIV * d1), 16'(lows));
		check("pacer at trigger", 16'h0001, 16'(pacer_out));
	endtask
	// soft trigger counts only while the pin source is deselected
	task automatic soft_test(input logic sel, input logic exp);
		ext_sel = sel;
		@(posedge mclk);
		#1 soft_trig = 1'b1;
		@(posedge mclk);
		#1 soft_trig = 1'b0;
		check("soft trigger", 16'(exp), 16'(conv_trig));
	endtask
	task automatic pretrig_test();
		ext_sel = 1'b1;
		i_host_model.arm(16'h0002);
		pretrig_en = 1'b1;
		i_host_model.pulse();
		check("count0 idle", 16'h0002, count0);
		i_host_model.stop_in = 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		check("gate open", 16'h0001, 16'(gate0));
		trigs = 0;
		i_host_model.pulse();
		check("count0 step", 16'h0001, count0);
		i_host_model.pulse();
		i_host_model.pulse();
		check("triggers", 16'h0002, 16'(trigs));
		check("count0 end", 16'h0000, count0);
		check("gate shut", 16'h0000, 16'(gate0));
		check("stopped", 16'h0001, 16'(stopped));
		pretrig_en = 1'b0;
		i_host_model.stop_in = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		check("rearmed", 16'h0000, 16'(stopped));
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		#1 rst_n = 1'b1;
		repeat (2) @(posedge mclk);
		mode_test();
		pacer_test(16'h0002, 16'h0002);
		pacer_test(16'h0003, 16'h0002);
		pretrig_test();
		soft_test(1'b1, 1'b0);
		soft_test(1'b0, 1'b1);
		give_verdict();
	end
	initial begin
		#400000;
		errors++;
		give_verdict();
	end
endmodule
